// ==== shared/dma_buffer_ram_defs.svh ====
// Purpose: constants for the dual-port buffer RAM
// Assumes: 16-bit byte-addressed data space, 2 Kbyte buffer at its top
// Notes: definitions only
`ifndef DMA_BUFFER_RAM_DEFS_SVH
`define DMA_BUFFER_RAM_DEFS_SVH

`define BUF_BYTES 2048
`define BUF_WORDS 1024
`define BUF_WIDX_W 10
`define EA_W 16
`define DATA_W 16
// buffer base; end of implemented data space is a plain default
`define BUF_BASE_EA 16'h7800
`define BUF_LAST_EA 16'h7FFF
// top of implemented data memory (30 Kbytes ends at 0x77FF, buffer follows)
`define DATA_TOP_EA 16'h7FFF
`define WORD_ZERO 16'h0000

`endif

// ==== shared/dma_buffer_ram_pkg.sv ====
// Purpose: types for the dual-port buffer RAM
// Assumes: constants come from the defs header
// Notes: types only
`include "dma_buffer_ram_defs.svh"
package dma_buffer_ram_pkg;
  typedef logic [`EA_W-1:0] ea_type;
  typedef logic [`DATA_W-1:0] word_type;
  typedef logic [`BUF_WIDX_W-1:0] widx_type;
endpackage : dma_buffer_ram_pkg

// ==== rtl/dual_port_dma_buffer_ram.sv ====
// Purpose: 2 Kbyte dual-ported buffer RAM at the top of Y data space
// Assumes: single clock mclk (40 MHz), async active-high reset; requests synchronous
// Notes: read data one cycle after the request; neither port ever waits
// What this block does
// - a 2 Kbyte memory with one CPU port and one DMA port that work independently.
// - the memory sits at the highest Y data addresses and is decoded as data memory.
// - both ports can complete an access in the same clock cycle.
// - DMA activity never stalls or delays a CPU access.
// - on a same-location write by both ports the CPU write wins.
// - the DMA port can both read data for peripherals and write data from them.
// - a CPU byte write changes only the lane chosen by the address LSB.
// - a CPU word access to an odd address raises an address error and writes nothing.
// - a CPU read outside implemented data memory returns zero.
`timescale 1ns/1ps
`include "dma_buffer_ram_defs.svh"

// ****************************************
// one byte lane of the buffer
// ****************************************
// two write lines and two read taps on one array; the caller keeps the
// write lines apart when both ports point at the same word
module buffer_byte_lane #(
  parameter int WORDS = `BUF_WORDS,
  parameter int IDX_W = `BUF_WIDX_W
) (
  input wire logic mclk,
  input wire logic cpu_wr,
  input wire logic [IDX_W-1:0] cpu_idx,
  input wire logic [7:0] cpu_byte_in,
  input wire logic dma_wr,
  input wire logic [IDX_W-1:0] dma_idx,
  input wire logic [7:0] dma_byte_in,
  output logic [7:0] cpu_byte_out,
  output logic [7:0] dma_byte_out
);
  logic [7:0] lane [0:WORDS-1];

  always_ff @(posedge mclk) begin
    if (cpu_wr) begin
      lane[cpu_idx] <= cpu_byte_in;
    end
    if (dma_wr) begin
      lane[dma_idx] <= dma_byte_in;
    end
  end

  // reads see the word as it stood before this edge's writes
  assign cpu_byte_out = lane[cpu_idx];
  assign dma_byte_out = lane[dma_idx];
endmodule : buffer_byte_lane

module dual_port_dma_buffer_ram (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_byte,
  input wire dma_buffer_ram_pkg::ea_type cpu_ea,
  input wire dma_buffer_ram_pkg::word_type cpu_wdata,
  output logic cpu_hit,
  output dma_buffer_ram_pkg::word_type cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_addr_err,
  output logic cpu_stall,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire dma_buffer_ram_pkg::widx_type dma_widx,
  input wire dma_buffer_ram_pkg::word_type dma_wdata,
  output dma_buffer_ram_pkg::word_type dma_rdata,
  output logic dma_rvalid,
  output logic dma_write_lost
);
  import dma_buffer_ram_pkg::*;

  // ****************************************
  // decode
  // ****************************************
  logic [7:0] cpu_lo_q;
  logic [7:0] cpu_hi_q;
  logic [7:0] dma_lo_q;
  logic [7:0] dma_hi_q;
  logic [7:0] cpu_hi_in;
  word_type next_cpu_rdata;
  logic next_cpu_rvalid;
  logic cpu_in_buf;
  logic cpu_in_data;
  logic cpu_misaligned;
  logic cpu_word_wr;
  logic cpu_lo_wr;
  logic cpu_hi_wr;
  logic dma_wr;
  logic collide;
  widx_type cpu_widx;

  assign cpu_in_buf = (cpu_ea >= `BUF_BASE_EA) && (cpu_ea <= `BUF_LAST_EA);
  assign cpu_in_data = cpu_ea <= `DATA_TOP_EA;
  assign cpu_widx = cpu_ea[`BUF_WIDX_W:1];
  assign cpu_misaligned = cpu_req && !cpu_byte && cpu_ea[0];
  assign cpu_word_wr = cpu_req && cpu_we && cpu_in_buf && !cpu_misaligned;
  // byte lane from the address LSB; word writes hit both lanes
  assign cpu_lo_wr = cpu_word_wr && (!cpu_byte || !cpu_ea[0]);
  assign cpu_hi_wr = cpu_word_wr && (!cpu_byte || cpu_ea[0]);
  assign collide = cpu_word_wr && dma_req && dma_we && (dma_widx == cpu_widx);
  // only the clashing DMA write is dropped; any other address goes through
  assign dma_wr = dma_req && dma_we && !collide;
  assign cpu_hit = cpu_req && cpu_in_buf;
  // the buffer is true dual-port, so the CPU side never waits
  assign cpu_stall = 1'b0;

  // ****************************************
  // storage
  // ****************************************
  // a byte write carries its data in the low byte, whichever lane it lands in
  assign cpu_hi_in = cpu_byte ? cpu_wdata[7:0] : cpu_wdata[15:8];

  // both ports write in the same cycle; collision already removed the DMA write
  buffer_byte_lane lo_lane_u (
    .mclk(mclk),
    .cpu_wr(cpu_lo_wr),
    .cpu_idx(cpu_widx),
    .cpu_byte_in(cpu_wdata[7:0]),
    .dma_wr(dma_wr),
    .dma_idx(dma_widx),
    .dma_byte_in(dma_wdata[7:0]),
    .cpu_byte_out(cpu_lo_q),
    .dma_byte_out(dma_lo_q)
  );

  buffer_byte_lane hi_lane_u (
    .mclk(mclk),
    .cpu_wr(cpu_hi_wr),
    .cpu_idx(cpu_widx),
    .cpu_byte_in(cpu_hi_in),
    .dma_wr(dma_wr),
    .dma_idx(dma_widx),
    .dma_byte_in(dma_wdata[15:8]),
    .cpu_byte_out(cpu_hi_q),
    .dma_byte_out(dma_hi_q)
  );

  // ****************************************
  // cpu read
  // ****************************************
  // read data holds until the next read on this port
  always_comb begin
    next_cpu_rdata = cpu_rdata;
    if (cpu_req && !cpu_we) begin
      if (!cpu_in_buf || cpu_misaligned) begin
        // outside the buffer this block answers zero; other data RAM muxes in
        next_cpu_rdata = `WORD_ZERO;
      end else if (cpu_byte) begin
        // selected byte lands in the low lane
        next_cpu_rdata = {8'h00, cpu_ea[0] ? cpu_hi_q : cpu_lo_q};
      end else begin
        next_cpu_rdata = {cpu_hi_q, cpu_lo_q};
      end
    end
  end

  assign next_cpu_rvalid = cpu_req && !cpu_we && cpu_in_data && !cpu_misaligned;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_rdata <= `WORD_ZERO;
    end else begin
      cpu_rdata <= next_cpu_rdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= next_cpu_rvalid;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_addr_err <= 1'b0;
    end else begin
      cpu_addr_err <= cpu_misaligned;
    end
  end

  // ****************************************
  // dma read and collision flag
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_rdata <= `WORD_ZERO;
    end else begin
      if (dma_req && !dma_we) begin
        dma_rdata <= {dma_hi_q, dma_lo_q};
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_rvalid <= 1'b0;
    end else begin
      dma_rvalid <= dma_req && !dma_we;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dma_write_lost <= 1'b0;
    end else begin
      dma_write_lost <= collide;
    end
  end
endmodule : dual_port_dma_buffer_ram

// ==== testbench/dma_buffer_ram_monitor.sv ====
// Purpose: port checker for the buffer RAM
// Assumes: one clock, async reset
// Notes: bound below
`timescale 1ns/1ps
module dma_buffer_ram_check (input wire logic mclk, reset, cpu_req, cpu_we, cpu_byte, cpu_hit,
  input wire logic cpu_rvalid, cpu_addr_err, cpu_stall, dma_req, dma_we, dma_rvalid,
  input wire logic dma_write_lost, input wire dma_buffer_ram_pkg::ea_type cpu_ea,
  input wire dma_buffer_ram_pkg::word_type cpu_rdata,
  input wire dma_buffer_ram_pkg::widx_type dma_widx);
  // ****
  // port relations
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic cw = cpu_req && cpu_we && cpu_hit && (cpu_byte || !cpu_ea[0]);
  wire logic col = cw && dma_req && dma_we && cpu_ea[10:1] == dma_widx;
  a_never_stall: assert property (!cpu_stall)
    else $error("cpu stall raised");
  a_hit_decode: assert property (cpu_hit == (cpu_req && cpu_ea[15:11] == 5'h0F))
    else $error("buffer decode wrong");
  a_cpu_read_ans: assert property (cpu_req && !cpu_we && !cpu_ea[15] && (cpu_byte || !cpu_ea[0]) |=> cpu_rvalid)
    else $error("cpu read not answered");
  a_dma_read_ans: assert property (dma_req && !dma_we |=> dma_rvalid)
    else $error("dma read not answered");
  a_odd_word_err: assert property (cpu_req && !cpu_byte && cpu_ea[0] |=> cpu_addr_err)
    else $error("odd word access not flagged");
  a_cpu_wins: assert property (col |=> dma_write_lost)
    else $error("clash not resolved");
  a_dma_kept: assert property (dma_req && dma_we && !(cpu_req && cpu_we) |=> !dma_write_lost)
    else $error("dma write dropped");
  a_far_zero: assert property (cpu_req && !cpu_we && cpu_ea[15] |=> !cpu_rvalid && cpu_rdata == 16'h0000)
    else $error("far read not zero");
  c_clash: cover property (col);
  c_both_read: cover property (cpu_req && !cpu_we && dma_req && !dma_we);
  c_odd: cover property (cpu_addr_err);
endmodule : dma_buffer_ram_check
bind dual_port_dma_buffer_ram dma_buffer_ram_check chk_u (.*);

// ==== testbench/dma_ctrl_model.sv ====
// Purpose: DMA controller side of the buffer RAM
// Assumes: called at the falling edge of mclk
// Notes: released write data shows the inverse of the last value
`timescale 1ns/1ps
module dma_ctrl_model (output logic dma_req, dma_we,
  output dma_buffer_ram_pkg::widx_type dma_widx, output dma_buffer_ram_pkg::word_type dma_wdata);
  // ****
  // request driving
  // ****
  initial begin
    dma_req = 0; dma_we = 0; dma_widx = '0; dma_wdata = '0;
  end
  task put(input logic we, input dma_buffer_ram_pkg::widx_type i, dma_buffer_ram_pkg::word_type d);
    dma_req = 1; dma_we = we; dma_widx = i; dma_wdata = d;
  endtask : put
  task idle();
    dma_req = 0; dma_wdata = ~dma_wdata;
  endtask : idle
endmodule : dma_ctrl_model

// ==== testbench/dual_port_dma_buffer_ram_test.sv ====
// Purpose: self-checking bench for the buffer RAM
// Assumes: inputs change at the falling edge
// Notes: one idle cycle between operations
`timescale 1ns/1ps
module dual_port_dma_buffer_ram_test;
  import dma_buffer_ram_pkg::*;
  logic mclk = 0, reset = 1, cpu_req = 0, cpu_we = 0, cpu_byte = 0;
  logic dma_req, dma_we, cpu_hit, cpu_rvalid, cpu_addr_err, cpu_stall, dma_rvalid, dma_write_lost;
  ea_type cpu_ea = '0;
  word_type cpu_wdata = '0, cpu_rdata, dma_rdata, dma_wdata;
  widx_type dma_widx;
  int num_errors = 0, num_checks = 0, cycles = 0;
  dma_ctrl_model dma_u (.dma_req(dma_req), .dma_we(dma_we), .dma_widx(dma_widx), .dma_wdata(dma_wdata));
  dual_port_dma_buffer_ram dut_u (.*);
  // ****
  // clock, timeout, helpers
  // ****
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (++cycles == 500) begin num_errors++; stop_test(); end
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin num_errors++; $display("MISMATCH %0t %s", $time, m); end
  endtask : chk
  task op(input logic cr, we, by, input ea_type a, input word_type d, input logic dr, dw,
    input widx_type i, input word_type dd);
    @(negedge mclk);
    cpu_req = cr; cpu_we = we; cpu_byte = by; cpu_ea = a; cpu_wdata = d;
    if (dr) dma_u.put(dw, i, dd);
    @(negedge mclk);
    cpu_req = 0; cpu_wdata = ~cpu_wdata;
    dma_u.idle();
  endtask : op
  task stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task t_ports();
    op(1, 1, 0, 16'h7800, 16'hA55A, 1, 1, 10'h3FF, 16'h1234);
    op(1, 0, 0, 16'h7FFE, 16'h0000, 1, 0, 10'h000, 16'h0000);
    chk(cpu_rvalid === 1'b1 && cpu_rdata === 16'h1234, "cpu read of dma word");
    chk(dma_rvalid === 1'b1 && dma_rdata === 16'hA55A, "dma read of cpu word");
    op(1, 1, 1, 16'h7801, 16'h00C3, 0, 0, 10'h000, 16'h0000);
    op(1, 0, 1, 16'h7801, 16'h0000, 0, 0, 10'h000, 16'h0000);
    chk(cpu_rvalid === 1'b1 && cpu_rdata === 16'h00C3, "byte read lane");
    op(0, 0, 0, 16'h7800, 16'h0000, 1, 0, 10'h000, 16'h0000);
    chk(dma_rdata === 16'hC35A, "byte lane write");
    $display("test ports done");
  endtask : t_ports
  task t_clash();
    op(1, 1, 0, 16'h7808, 16'h1111, 1, 1, 10'h004, 16'h2222);
    chk(dma_write_lost === 1'b1, "clash not flagged");
    op(1, 1, 0, 16'h780C, 16'h3333, 1, 1, 10'h005, 16'h4444);
    chk(dma_write_lost === 1'b0, "clean dma write lost");
    op(1, 0, 0, 16'h7808, 16'h0000, 1, 0, 10'h005, 16'h0000);
    chk(cpu_rdata === 16'h1111 && dma_rdata === 16'h4444, "data after clash");
    chk(cpu_stall === 1'b0, "cpu stalled");
    $display("test clash done");
  endtask : t_clash
  task t_edge();
    op(1, 1, 0, 16'h7801, 16'hFFFF, 0, 0, 10'h000, 16'h0000);
    chk(cpu_addr_err === 1'b1, "odd word not flagged");
    op(1, 0, 0, 16'h8000, 16'h0000, 1, 0, 10'h000, 16'h0000);
    chk(cpu_rvalid === 1'b0 && cpu_rdata === 16'h0000, "far read not zero");
    chk(dma_rdata === 16'hC35A, "odd word write stored");
    op(1, 1, 0, 16'h7800, 16'h5A5A, 0, 0, 10'h000, 16'h0000);
    op(1, 0, 0, 16'h1000, 16'h0000, 0, 0, 10'h000, 16'h0000);
    chk(cpu_rvalid === 1'b1 && cpu_rdata === 16'h0000, "non-buffer read");
    $display("test edge done");
  endtask : t_edge
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 0;
    t_ports();
    t_clash();
    t_edge();
    stop_test();
  end
endmodule : dual_port_dma_buffer_ram_test
